// *** rtl/tgsp_pkg.sv ***
// Package for the timer group, simultaneous-start and write-protect control.
// Holds register byte addresses, field positions, reset values and the
// protected-address table shared by the control block and its decoder.
package tgsp_pkg;

  // ==========================================================================
  // Bus widths and counts
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 5;
  localparam int NUM_PIN = 6;
  localparam int NUM_PROT = 24;

  // ==========================================================================
  // Register byte addresses
  localparam logic [19:0] OUT_MASTER_EN_ADDR = 20'h9520a;
  localparam logic [19:0] GROUP_SEL_ADDR     = 20'h95281;
  localparam logic [19:0] START_ARM_ADDR     = 20'h95282;
  localparam logic [19:0] ACCESS_EN_ADDR     = 20'h95284;

  // ==========================================================================
  // Field positions
  localparam int GROUP_LOW_LSB = 0;   // Channels 0..2 at bits 0..2
  localparam int GROUP_HIGH_LSB = 6;  // Channels 3..4 at bits 6..7
  localparam int ARM_CH4_BIT = 3;     // Arm bits run ch4 at bit 3 up to ch0 at bit 7
  localparam int UNLOCK_BIT = 0;
  localparam int PIN_EN_W = 6;

  // ==========================================================================
  // Values after reset and fixed read values
  localparam logic [4:0] GROUP_SEL_RST   = 5'h00;
  localparam logic [4:0] START_ARM_RST   = 5'h00;
  localparam logic       UNLOCK_RST      = 1'b1;
  localparam logic [5:0] PIN_EN_RST      = 6'h00;
  localparam logic [1:0] OME_RESERVED_RD = 2'h3;  // Reserved top bits read as ones while unlocked
  localparam logic [7:0] UNMAPPED_RD     = 8'h00;

  // ==========================================================================
  // Protected registers: byte address, and whether the entry is a 16-bit
  // register whose odd byte must match too
  localparam logic [19:0] PROT_ADDR [NUM_PROT] = '{
    20'h95200, 20'h95201, 20'h95202, 20'h95204, 20'h95205, 20'h95208,
    20'h95210, 20'h95218, 20'h9521c, 20'h95220, 20'h95221, 20'h95222,
    20'h95206, 20'h95207, 20'h95209, 20'h9521a, 20'h9521e, 20'h95212,
    20'h9520a, 20'h9520e, 20'h9520f, 20'h9520d, 20'h95214, 20'h95216
  };
  localparam logic [NUM_PROT-1:0] PROT_WIDE = 24'h7e0fc0;

endpackage : tgsp_pkg

// *** rtl/tgsp_prot_decode.sv ***
// Address decoder for the set of write-protected registers and counters.
// Assumes byte addresses on the register bus; 16-bit entries match either byte.
`timescale 1ns/10ps
`default_nettype none

module tgsp_prot_decode
  import tgsp_pkg::*;
(
  // Address under test
  input  wire logic [ADDR_W-1:0] addr,
  // Match result
  output logic                   isProt
);

  logic [NUM_PROT-1:0] hit;

  // ==========================================================================
  // Compare against every table entry
  genvar g;
  generate
    for (g = 0; g < NUM_PROT; g++) begin : g_cmp
      // Wide entries ignore the byte-select bit
      assign hit[g] = ({addr[ADDR_W-1:1], addr[0] & ~PROT_WIDE[g]} == PROT_ADDR[g]); // RULE11
    end
  endgenerate

  assign isProt = |hit; // RULE11

endmodule : tgsp_prot_decode
`default_nettype wire

// *** rtl/tgsp_ctrl.sv ***
// Shared control of five timer channels: group-select, simultaneous start,
// protection unlock for channels 3/4 and the six pin master enables.
// Assumes the counter-start register, counters and I/O control live outside
// and hand in their write strobes; all inputs are on the clk domain.
//
// Behaviour
// (RULE1) Group-select 1 joins channel to group; 0 keeps group set/clear away.
// (RULE2) Group-select bits: ch0..2 at bits 0..2, ch3..4 at 6..7, 3..5 zero.
// (RULE3) Grouped counters load together and clear when another grouped one clears.
// (RULE4) Software selects at least two channels for grouping to mean anything.
// (RULE5) Software also picks group clearing in the channel's clear source field.
// (RULE6) Arm bits: ch4 bit3 up to ch0 bit7; bits 0..2 read zero.
// (RULE7) Arm bits are set by writing 1; writing 0 leaves them alone.
// (RULE8) Arm bit clears when its channel's run bit is written 1 while armed.
// (RULE9) Unlock bit 0 enables protected access; bits 1..7 read zero.
// (RULE10) Unlock clears only by a 0 write after a read returned 1.
// (RULE11) The protected set holds 24 registers and counters of channels 3/4.
// (RULE12) Pin enables: c3b b0, c4a b1, c4b b2, c3d b3, c4c b4, c4d b5.
// (RULE13) Master-enable bits 6 and 7 read as one; the code returns zero for the whole byte while locked.
// (RULE14) Software sets master enables before channel 3/4 I/O control.
// (RULE15) Software writes master enables only with run_ch3 and run_ch4 at 0.
// (RULE16) Software readies port direction and data before switching pin to GPIO.
// (RULE17) Starting any armed channel starts all armed ones and clears all arms.
// (RULE18) While locked, writes to protected registers and counters are discarded.
`timescale 1ns/10ps
`default_nettype none

module tgsp_ctrl
  import tgsp_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // Register port
  input  wire logic [ADDR_W-1:0]   regAddr,
  input  wire logic [DATA_W-1:0]   regWrData,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output logic      [DATA_W-1:0]   regRdData,
  // Protection gate for registers held elsewhere
  output logic                     extWrAllow,
  output logic                     extRdAllow,
  output logic                     protectionUnlock,
  // Counter-start register write seen from outside
  input  wire logic                startWr,
  input  wire logic [NUM_CH-1:0]   startWrData,
  output logic      [NUM_CH-1:0]   runStart,
  // Group set and clear
  input  wire logic [NUM_CH-1:0]   counterWr,
  input  wire logic [NUM_CH-1:0]   counterClearEvt,
  input  wire logic [NUM_CH-1:0]   clearSrcGroup,
  output logic      [NUM_CH-1:0]   groupLoad,
  output logic      [NUM_CH-1:0]   groupClear,
  output logic      [NUM_CH-1:0]   groupSel,
  // Pin master enables
  output logic      [NUM_PIN-1:0]  pinEnable
);

  // ==========================================================================
  // Field mapping helpers

  // Group-select layout: low three channels, gap, then channels 3 and 4
  function automatic logic [7:0] group_to_byte(input logic [4:0] g);
    group_to_byte = {g[4:3], 3'h0, g[2:0]}; // RULE2
  endfunction : group_to_byte

  // Arm layout runs backwards: channel 0 sits in the top bit
  function automatic logic [4:0] arm_from_byte(input logic [7:0] b);
    arm_from_byte = {b[ARM_CH4_BIT], b[ARM_CH4_BIT+1], b[ARM_CH4_BIT+2],
                     b[ARM_CH4_BIT+3], b[ARM_CH4_BIT+4]}; // RULE6
  endfunction : arm_from_byte

  function automatic logic [7:0] arm_to_byte(input logic [4:0] a);
    arm_to_byte = {a[0], a[1], a[2], a[3], a[4], 3'h0}; // RULE6
  endfunction : arm_to_byte

  // ==========================================================================
  // Address decode
  logic isProt;
  logic selOme;
  logic selGroup;
  logic selArm;
  logic selAccess;
  logic wrOme;
  logic wrGroup;
  logic wrArm;
  logic wrAccess;
  logic rdAccess;

  tgsp_prot_decode u_prot (
    .addr   (regAddr),
    .isProt (isProt)
  );

  assign selOme    = (regAddr == OUT_MASTER_EN_ADDR);
  assign selGroup  = (regAddr == GROUP_SEL_ADDR);
  assign selArm    = (regAddr == START_ARM_ADDR);
  assign selAccess = (regAddr == ACCESS_EN_ADDR);

  // ==========================================================================
  // Protection unlock
  logic unlock_q;
  logic unlock_d;
  logic seenOne_q;
  logic seenOne_d;

  // Protected writes die here while locked, including the local master enables
  assign wrOme      = regWr & selOme & unlock_q;                 // RULE18
  assign wrGroup    = regWr & selGroup;
  assign wrArm      = regWr & selArm;
  assign wrAccess   = regWr & selAccess;
  assign rdAccess   = regRd & selAccess;
  assign extWrAllow = regWr & isProt & ~selOme & unlock_q;       // RULE18
  assign extRdAllow = regRd & isProt & ~selOme & unlock_q;       // RULE9
  assign protectionUnlock = unlock_q;

  // Remember a read that showed the unlock set; a write to the access-enable register cancels it
  always_comb begin
    seenOne_d = seenOne_q;
    if (rdAccess) begin
      seenOne_d = unlock_q;                                      // RULE10
    end else if (wrAccess) begin
      seenOne_d = 1'b0;
    end
  end

  // A 0 write counts only after the read returned 1, so a stray store
  // from runaway code cannot relock by accident; a 1 write unlocks at once
  always_comb begin
    unlock_d = unlock_q;
    if (wrAccess) begin
      if (regWrData[UNLOCK_BIT]) begin
        unlock_d = 1'b1;                                         // RULE9
      end else if (seenOne_q) begin
        unlock_d = 1'b0;                                         // RULE10
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      unlock_q  <= UNLOCK_RST;
      seenOne_q <= 1'b0;
    end else begin
      unlock_q  <= unlock_d;
      seenOne_q <= seenOne_d;
    end
  end

  // ==========================================================================
  // Output master enables
  logic [NUM_PIN-1:0] pinEn_q;

  // Bits 6 and 7 are not stored; they read as ones while unlocked
  always_ff @(posedge clk) begin
    if (srst) begin
      pinEn_q <= PIN_EN_RST;
    end else if (wrOme) begin
      pinEn_q <= regWrData[PIN_EN_W-1:0];                        // RULE12
    end
  end

  assign pinEnable = pinEn_q; // RULE12

  // ==========================================================================
  // Group select
  logic [NUM_CH-1:0] group_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      group_q <= GROUP_SEL_RST;
    end else if (wrGroup) begin
      group_q <= {regWrData[GROUP_HIGH_LSB+1:GROUP_HIGH_LSB],
                  regWrData[GROUP_LOW_LSB+2:GROUP_LOW_LSB]};     // RULE2
    end
  end

  assign groupSel = group_q;

  // ==========================================================================
  // Simultaneous start
  logic [NUM_CH-1:0] arm_q;
  logic [NUM_CH-1:0] arm_d;
  logic              armedHit;
  logic [NUM_CH-1:0] runStart_q;

  // Any armed channel written to run fires the whole armed set at once
  assign armedHit = startWr & |(startWrData & arm_q);            // RULE17

  // Set beats clear: a 1 written in the firing cycle survives
  always_comb begin
    arm_d = arm_q;
    if (armedHit) begin
      arm_d = '0;                                                // RULE8 RULE17
    end
    if (wrArm) begin
      arm_d = arm_d | arm_from_byte(regWrData);                  // RULE7
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      arm_q <= START_ARM_RST;
    end else begin
      arm_q <= arm_d;
    end
  end

  // One-cycle start pulse per channel, armed ones joined in
  always_ff @(posedge clk) begin
    if (srst) begin
      runStart_q <= '0;
    end else if (startWr) begin
      runStart_q <= startWrData | (armedHit ? arm_q : '0);       // RULE17
    end else begin
      runStart_q <= '0;
    end
  end

  assign runStart = runStart_q;

  // ==========================================================================
  // Group set and clear
  logic [NUM_CH-1:0] groupLoad_q;
  logic [NUM_CH-1:0] groupClear_q;
  logic              anyGroupWr;
  logic [NUM_CH-1:0] groupClrSrc;

  // Only grouped channels take part on either side
  assign anyGroupWr  = |(counterWr & group_q);                   // RULE1
  assign groupClrSrc = counterClearEvt & group_q;                // RULE1

  // Loads and clears go out one cycle late so all members move together
  always_ff @(posedge clk) begin
    if (srst) begin
      groupLoad_q  <= '0;
      groupClear_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        groupLoad_q[i]  <= group_q[i] & anyGroupWr;              // RULE3
        groupClear_q[i] <= group_q[i] & clearSrcGroup[i] &
                           |(groupClrSrc & ~(NUM_CH'(1) << i));  // RULE3
      end
    end
  end

  assign groupLoad  = groupLoad_q;
  assign groupClear = groupClear_q;

  // ==========================================================================
  // Read data, one cycle after the strobe
  logic [DATA_W-1:0] rdMux;

  always_comb begin
    rdMux = UNMAPPED_RD;
    if (selOme) begin
      // Locked reads of the protected master enables return zero
      rdMux = unlock_q ? {OME_RESERVED_RD, pinEn_q} : UNMAPPED_RD; // RULE13 RULE9
    end else if (selGroup) begin
      rdMux = group_to_byte(group_q);                            // RULE2
    end else if (selArm) begin
      rdMux = arm_to_byte(arm_q);                                // RULE6
    end else if (selAccess) begin
      rdMux = {7'h00, unlock_q};                                 // RULE9
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      regRdData <= '0;
    end else if (regRd) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= '0;
    end
  end

endmodule : tgsp_ctrl
`default_nettype wire

// *** verif/tgsp_ctrl_sva.sv ***
// Checker for the group, start-arm and protection control block.
// Sees only the top module ports; bound to every tgsp_ctrl instance.
`timescale 1ns/10ps
`default_nettype none

module tgsp_ctrl_sva
  import tgsp_pkg::*;
(
  // Clock and reset
  input wire logic               clk,
  input wire logic               srst,
  // Register port
  input wire logic [ADDR_W-1:0]  regAddr,
  input wire logic [DATA_W-1:0]  regWrData,
  input wire logic               regWr,
  input wire logic               regRd,
  input wire logic [DATA_W-1:0]  regRdData,
  // Protection gate
  input wire logic               extWrAllow,
  input wire logic               extRdAllow,
  input wire logic               protectionUnlock,
  // Start, group and pins
  input wire logic               startWr,
  input wire logic [NUM_CH-1:0]  startWrData,
  input wire logic [NUM_CH-1:0]  runStart,
  input wire logic [NUM_CH-1:0]  counterWr,
  input wire logic [NUM_CH-1:0]  counterClearEvt,
  input wire logic [NUM_CH-1:0]  clearSrcGroup,
  input wire logic [NUM_CH-1:0]  groupLoad,
  input wire logic [NUM_CH-1:0]  groupClear,
  input wire logic [NUM_CH-1:0]  groupSel,
  input wire logic [NUM_PIN-1:0] pinEnable
);
  // ==========================================================================
  // One clock domain, so clock and reset are named once
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_LOAD_GROUPED: assert property (
    |(counterWr & groupSel) |=> groupLoad == $past(groupSel)) else $error("group load wrong");
  AST_LOAD_LONE: assert property (
    !(|(counterWr & groupSel)) |=> groupLoad == 5'h00) else $error("ungrouped load");
  AST_CLEAR_SRC: assert property (
    groupClear != 5'h00 |-> |($past(counterClearEvt) & $past(groupSel))
      && (groupClear & ~($past(groupSel) & $past(clearSrcGroup))) == 5'h00)
    else $error("group clear without cause");
  AST_RUN_DATA: assert property (
    startWr |=> (runStart & $past(startWrData)) == $past(startWrData)) else $error("run lost");
  AST_RUN_IDLE: assert property (
    !startWr |=> runStart == 5'h00) else $error("run without start write");
  AST_WR_ALLOW: assert property (
    extWrAllow |-> regWr && protectionUnlock && regAddr != OUT_MASTER_EN_ADDR)
    else $error("protected write let through");
  AST_RD_ALLOW: assert property (
    extRdAllow |-> regRd && protectionUnlock) else $error("protected read let through");
  AST_PIN_HOLD: assert property (
    !(regWr && regAddr == OUT_MASTER_EN_ADDR && protectionUnlock) |=> $stable(pinEnable))
    else $error("pin enables moved");
  AST_UNLOCK_CLR: assert property (
    $fell(protectionUnlock) |-> $past(regWr) && $past(regAddr) == ACCESS_EN_ADDR)
    else $error("unlock dropped without write");
  AST_RD_IDLE: assert property (
    !regRd |=> regRdData == 8'h00) else $error("read data outside its cycle");
endmodule : tgsp_ctrl_sva

bind tgsp_ctrl tgsp_ctrl_sva u_sva (.clk(clk), .srst(srst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .extWrAllow(extWrAllow), .extRdAllow(extRdAllow), .protectionUnlock(protectionUnlock),
  .startWr(startWr), .startWrData(startWrData), .runStart(runStart),
  .counterWr(counterWr), .counterClearEvt(counterClearEvt), .clearSrcGroup(clearSrcGroup),
  .groupLoad(groupLoad), .groupClear(groupClear), .groupSel(groupSel),
  .pinEnable(pinEnable));

`default_nettype wire

// *** verif/tgsp_ctrl_tb.sv ***
// Self-checking bench for the timer group and protection control block.
// Drives every port itself; the checker is bound from its own file.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) chk(8'(g), 8'(e))

module tgsp_ctrl_tb
  import tgsp_pkg::*;
;
  logic        clk, srst, regWr, regRd, startWr, wAllow, rAllow;
  logic [19:0] regAddr;
  logic [7:0]  regWrData, regRdData;
  logic        extWrAllow, extRdAllow, protectionUnlock;
  logic [4:0]  startWrData, runStart, counterWr, counterClearEvt;
  logic [4:0]  clearSrcGroup, groupLoad, groupClear, groupSel;
  logic [5:0]  pinEnable;
  int          errTotal, totalChecks, cyc;

  tgsp_ctrl u_tgsp_ctrl (.clk(clk), .srst(srst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .extWrAllow(extWrAllow), .extRdAllow(extRdAllow), .protectionUnlock(protectionUnlock),
    .startWr(startWr), .startWrData(startWrData), .runStart(runStart),
    .counterWr(counterWr), .counterClearEvt(counterClearEvt), .clearSrcGroup(clearSrcGroup),
    .groupLoad(groupLoad), .groupClear(groupClear), .groupSel(groupSel),
    .pinEnable(pinEnable));

  // ==========================================================================
  // Compare, bus cycles and event pulses
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Write; the combinational gate is caught mid-cycle
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    #1 wAllow = extWrAllow;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask : wr

  // Read; data stand only in the cycle after the strobe
  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    #1 rAllow = extRdAllow;
    @(posedge clk);
    regRd <= 1'b0;
    #1 `CHK(regRdData, e);
  endtask : rd

  task automatic ev(input logic s, input logic [4:0] c, input logic [4:0] k, input logic [4:0] d);
    @(posedge clk);
    startWr         <= s;
    counterWr       <= c;
    counterClearEvt <= k;
    startWrData     <= d;
    @(posedge clk);
    startWr         <= 1'b0;
    counterWr       <= 5'h00;
    counterClearEvt <= 5'h00;
    #1;
  endtask : ev

  task automatic reportAndStop;
    $display("checks=%0d mismatches=%0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : reportAndStop

  // ==========================================================================
  // Clock, and a ceiling well above the roughly 90 cycles used
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errTotal++;
      reportAndStop;
    end
  end

  // ==========================================================================
  // Main sequence; ch3 is kept off group clearing to test the source select
  initial begin
    {regWr, regRd, startWr, srst} = 4'h1;
    {regAddr, regWrData, startWrData, counterWr, counterClearEvt} = '0;
    clearSrcGroup = 5'h17;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(GROUP_SEL_ADDR, 8'h00);
    rd(START_ARM_ADDR, 8'h00);
    rd(ACCESS_EN_ADDR, 8'h01);
    rd(OUT_MASTER_EN_ADDR, 8'hc0);
    rd(20'h95283, 8'h00);
    wr(GROUP_SEL_ADDR, 8'hff);
    rd(GROUP_SEL_ADDR, 8'hc7);
    wr(GROUP_SEL_ADDR, 8'h41);
    `CHK(groupSel, 8'h09);
    ev(1'b0, 5'h08, 5'h00, 5'h00);
    `CHK(groupLoad, 8'h09);
    ev(1'b0, 5'h02, 5'h00, 5'h00);
    `CHK(groupLoad, 8'h00);
    ev(1'b0, 5'h00, 5'h08, 5'h00);
    `CHK(groupClear, 8'h01);
    ev(1'b0, 5'h00, 5'h01, 5'h00);
    `CHK(groupClear, 8'h00);
    wr(START_ARM_ADDR, 8'h07);
    rd(START_ARM_ADDR, 8'h00);
    wr(START_ARM_ADDR, 8'h30);
    wr(START_ARM_ADDR, 8'h00);
    rd(START_ARM_ADDR, 8'h30);
    ev(1'b1, 5'h00, 5'h00, 5'h04);
    `CHK(runStart, 8'h0c);
    rd(START_ARM_ADDR, 8'h00);
    wr(START_ARM_ADDR, 8'h08);
    ev(1'b1, 5'h00, 5'h00, 5'h01);
    `CHK(runStart, 8'h01);
    rd(START_ARM_ADDR, 8'h08);
    ev(1'b1, 5'h00, 5'h00, 5'h10);
    `CHK(runStart, 8'h10);
    rd(START_ARM_ADDR, 8'h00);
    // Stop channels 3 and 4 before touching the master enables
    ev(1'b1, 5'h00, 5'h00, 5'h00);
    `CHK(runStart, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(OUT_MASTER_EN_ADDR, 8'hc0 | (8'h01 << i));
      `CHK(pinEnable, 8'h01 << i);
    end
    rd(OUT_MASTER_EN_ADDR, 8'he0);
    // A write cancels the earlier read of 1, so the 0 write must be ignored
    wr(ACCESS_EN_ADDR, 8'h01);
    wr(ACCESS_EN_ADDR, 8'h00);
    `CHK(protectionUnlock, 8'h01);
    wr(PROT_ADDR[0], 8'h5a);
    `CHK(wAllow, 8'h01);
    rd(PROT_ADDR[0], 8'h00);
    `CHK(rAllow, 8'h01);
    rd(ACCESS_EN_ADDR, 8'h01);
    wr(ACCESS_EN_ADDR, 8'h00);
    `CHK(protectionUnlock, 8'h00);
    rd(ACCESS_EN_ADDR, 8'h00);
    wr(PROT_ADDR[23], 8'h5a);
    `CHK(wAllow, 8'h00);
    rd(PROT_ADDR[5], 8'h00);
    `CHK(rAllow, 8'h00);
    wr(OUT_MASTER_EN_ADDR, 8'hff);
    `CHK(pinEnable, 8'h20);
    rd(OUT_MASTER_EN_ADDR, 8'h00);
    wr(ACCESS_EN_ADDR, 8'h01);
    `CHK(protectionUnlock, 8'h01);
    reportAndStop;
  end
endmodule : tgsp_ctrl_tb

`default_nettype wire
